// file: rtl/sdli_device.sv
// Converter end: serial frame loader, converter register and interpolator
//
// Summary of operation
// - Code is unsigned binary, 0 to 262143
// - Core code bits 19..4, interp bits 3..2
// - Time at C+1 is 0/25/50/75 percent
// - Interpolator refreshes core input at 10 kHz
// - Frame starts on falling frame select
// - Sample data on falling serial clock edges
// - 24th falling edge latches the code; converter register loads on the third system clock edge after it
// - Host holds frame select high 2 cycles (50 ns), over the 33 ns minimum
// - Host idles frame select low between frames
// - Frame: 2 ignored, 2 reserved, 18 code, 2 ignored
// - Host sends most significant bit first
// - Early frame select rise discards frame
// - Reset code held until first valid frame
// - Byte hosts keep frame select low throughout
// - Master uses polarity 0, phase 1
`timescale 1ns/1ps
module sdli_device
  import sdli_pkg::*;
#(
  parameter bit MIDSCALE_VARIANT = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  sdli_link_if.dev_mp link,
  output logic [17:0] dac_code_q,
  output logic [15:0] core_code_q,
  output logic load_pulse_q,
  output logic rsv_nonzero_q,
  output logic period_start_q
);
  localparam logic [17:0] RST_CODE = MIDSCALE_VARIANT ? RST_CODE_MID : RST_CODE_ZERO;

  // Link clock domain
  logic [23:0] shift_q;
  logic [4:0] bit_cnt_q;
  logic [17:0] hold_code_q;
  logic hold_rsv_q;
  logic frame_tgl_q;
  logic [23:0] shift_next;

  // System clock domain
  logic tgl_s1_q;
  logic tgl_s2_q;
  logic tgl_s3_q;
  logic load_evt;
  logic [9:0] sub_cnt_q;
  logic [1:0] phase_q;
  logic [15:0] core_base;
  logic [1:0] interp_code;
  logic bump;

  // Code field of a complete frame
  function automatic logic [17:0] frame_code(input logic [23:0] frame);
    return frame[CORE_MSB_POS:CODE_LSB_POS];
  endfunction : frame_code

  // Reserved bits of a complete frame are not all zero
  function automatic logic frame_rsv(input logic [23:0] frame);
    return frame[RSV_HI_POS] | frame[RSV_LO_POS];
  endfunction : frame_rsv

  // Last cycle of a sub-period
  function automatic logic sub_last(input logic [9:0] cnt);
    return cnt == 10'(SUB_PERIOD_CYC - 1);
  endfunction : sub_last

  assign shift_next = {shift_q[22:0], link.din};

  // Shift register; frame select high clears it
  always_ff @(negedge link.sclk or negedge rst_n or posedge link.sync_n) begin
    if (!rst_n) begin
      shift_q <= '0;
    end else if (link.sync_n) begin
      shift_q <= '0;
    end else if (bit_cnt_q != BIT_CNT_DONE) begin
      shift_q <= shift_next;
    end
  end

  // Bit count; armed out of reset, since the host idles frame select high there
  always_ff @(negedge link.sclk or negedge rst_n or posedge link.sync_n) begin
    if (!rst_n) begin
      bit_cnt_q <= '0;
    end else if (link.sync_n) begin
      bit_cnt_q <= '0;
    end else if (bit_cnt_q != BIT_CNT_DONE) begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  // Code of a complete frame, taken on its last falling edge
  always_ff @(negedge link.sclk or negedge rst_n) begin
    if (!rst_n) begin
      hold_code_q <= RST_CODE;
    end else if (!link.sync_n && bit_cnt_q == BIT_CNT_LAST) begin
      hold_code_q <= frame_code(shift_next);
    end
  end

  // Reserved flag of the same frame
  always_ff @(negedge link.sclk or negedge rst_n) begin
    if (!rst_n) begin
      hold_rsv_q <= 1'b0;
    end else if (!link.sync_n && bit_cnt_q == BIT_CNT_LAST) begin
      hold_rsv_q <= frame_rsv(shift_next);
    end
  end

  // Frame event toggle, one change per complete frame
  always_ff @(negedge link.sclk or negedge rst_n) begin
    if (!rst_n) begin
      frame_tgl_q <= 1'b0;
    end else if (!link.sync_n && bit_cnt_q == BIT_CNT_LAST) begin
      frame_tgl_q <= ~frame_tgl_q;
    end
  end

  // Frame event crossing into the system clock
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
    end else begin
      tgl_s1_q <= frame_tgl_q;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
    end
  end

  assign load_evt = tgl_s2_q ^ tgl_s3_q;

  // Converter register, forced to the power-on code until a full frame
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dac_code_q <= RST_CODE;
    end else if (load_evt) begin
      dac_code_q <= hold_code_q;
    end
  end

  // Reserved flag of the loaded frame
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rsv_nonzero_q <= 1'b0;
    end else if (load_evt) begin
      rsv_nonzero_q <= hold_rsv_q;
    end
  end

  // One-cycle pulse for each load
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      load_pulse_q <= 1'b0;
    end else begin
      load_pulse_q <= load_evt;
    end
  end

  assign core_base = dac_code_q[CODE_BITS-1:INTERP_BITS];
  assign interp_code = dac_code_q[INTERP_BITS-1:0];

  // Sub-period counter
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sub_cnt_q <= '0;
    end else if (sub_last(sub_cnt_q)) begin
      sub_cnt_q <= '0;
    end else begin
      sub_cnt_q <= sub_cnt_q + 10'h001;
    end
  end

  // Phase: index of the current sub-period within the period
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= '0;
    end else if (sub_last(sub_cnt_q)) begin
      phase_q <= phase_q + 2'h1;
    end
  end

  // Pulse as the phase wraps to the first sub-period
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      period_start_q <= 1'b0;
    end else begin
      period_start_q <= sub_last(sub_cnt_q) && (phase_q == 2'(SUB_PERIODS - 1));
    end
  end

  // Below CORE_MAX, step to C+1 for as many sub-periods as the interpolator code
  assign bump = (phase_q < interp_code) && (core_base != CORE_MAX);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      core_code_q <= RST_CODE[CODE_BITS-1:INTERP_BITS];
    end else begin
      core_code_q <= core_base + 16'(bump);
    end
  end
endmodule : sdli_device

// file: rtl/sdli_pkg.sv
// Shared constants for the serial converter loader and interpolator
package sdli_pkg;
  localparam int FRAME_BITS = 24;
  localparam int CODE_BITS = 18;
  localparam int CORE_BITS = 16;
  localparam int INTERP_BITS = 2;
  localparam int RSV_HI_POS = 21;
  localparam int RSV_LO_POS = 20;
  localparam int CORE_MSB_POS = 19;
  localparam int CORE_LSB_POS = 4;
  localparam int INTERP_MSB_POS = 3;
  localparam int INTERP_LSB_POS = 2;
  localparam int CODE_LSB_POS = 2;
  localparam int CODE_FULL_SCALE = 262144;
  localparam logic [17:0] CODE_MAX = 18'h3ffff;
  localparam logic [15:0] CORE_MAX = 16'hffff;
  localparam logic [17:0] RST_CODE_ZERO = 18'h00000;
  localparam logic [17:0] RST_CODE_MID = 18'h20000;
  localparam logic [4:0] BIT_CNT_LAST = 5'h17;
  localparam logic [4:0] BIT_CNT_DONE = 5'h18;
  localparam int CLK_SYS_PERIOD_NS = 25;
  localparam int CLK_SYS_HZ = 40000000;
  localparam int INTERP_RATE_HZ = 10000;
  localparam int INTERP_PERIOD_CYC = CLK_SYS_HZ / INTERP_RATE_HZ;
  localparam int SUB_PERIODS = 4;
  localparam int SUB_PERIOD_CYC = INTERP_PERIOD_CYC / SUB_PERIODS;
  localparam int SYNC_HIGH_MIN_NS = 33;
  localparam int SYNC_HIGH_CYC = (SYNC_HIGH_MIN_NS + CLK_SYS_PERIOD_NS - 1) / CLK_SYS_PERIOD_NS;
  localparam int SCLK_HALF_CYC = 2;
  localparam int FIFO_DEPTH = 4;
  typedef enum logic [1:0] {
    SDLI_IDLE = 2'b00,
    SDLI_GAP = 2'b01,
    SDLI_SHIFT = 2'b10
  } sdli_host_state_e;
endpackage : sdli_pkg

// file: rtl/sdli_link_if.sv
// Three-wire serial link between the host and the converter
`timescale 1ns/1ps
interface sdli_link_if;
  logic sync_n;
  logic sclk;
  logic din;
  modport host_mp (
    output sync_n,
    output sclk,
    output din
  );
  modport dev_mp (
    input sync_n,
    input sclk,
    input din
  );
endinterface : sdli_link_if

// file: rtl/sdli_fifo.sv
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module sdli_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_q];
  assign cnt_d = cnt_q + CW'(push) - CW'(pop);

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_d;
      in_ready <= (cnt_d != CW'(DEPTH));
      out_valid <= (cnt_d != '0);
    end
  end
endmodule : sdli_fifo

// file: rtl/sdli_host.sv
// Host end: queues codes and sends 24-bit frames on the serial link
`timescale 1ns/1ps
module sdli_host
  import sdli_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  sdli_link_if.host_mp link,
  input wire logic [17:0] code_data,
  input wire logic code_valid,
  output logic code_ready,
  output logic busy_q
);
  sdli_host_state_e state_q;
  logic [17:0] fifo_data;
  logic fifo_valid;
  logic fifo_pop;
  logic [23:0] shift_q;
  logic [4:0] bit_cnt_q;
  logic [1:0] div_q;
  logic [1:0] gap_q;
  logic sync_n_q;
  logic sclk_q;
  logic din_q;

  assign fifo_pop = (state_q == SDLI_IDLE);
  assign link.sync_n = sync_n_q;
  assign link.sclk = sclk_q;
  assign link.din = din_q;

  sdli_fifo #(
    .WIDTH(CODE_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_data(code_data),
    .in_valid(code_valid),
    .in_ready(code_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  // Frame sequencer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SDLI_IDLE;
      sync_n_q <= 1'b1;
      sclk_q <= 1'b0;
      din_q <= 1'b0;
      shift_q <= '0;
      bit_cnt_q <= '0;
      div_q <= '0;
      gap_q <= '0;
      busy_q <= 1'b0;
    end else begin
      unique case (state_q)
        SDLI_IDLE: begin
          busy_q <= fifo_valid;
          if (fifo_valid) begin
            shift_q <= {4'h0, fifo_data, 2'h0};
            sync_n_q <= 1'b1;
            gap_q <= '0;
            state_q <= SDLI_GAP;
          end
        end
        SDLI_GAP: begin
          if (gap_q == 2'(SYNC_HIGH_CYC - 1)) begin
            sync_n_q <= 1'b0;
            div_q <= '0;
            bit_cnt_q <= '0;
            state_q <= SDLI_SHIFT;
          end else begin
            gap_q <= gap_q + 2'h1;
          end
        end
        SDLI_SHIFT: begin
          if (div_q == 2'(SCLK_HALF_CYC - 1)) begin
            div_q <= '0;
            if (!sclk_q) begin
              sclk_q <= 1'b1;
              din_q <= shift_q[FRAME_BITS-1];
              shift_q <= {shift_q[22:0], 1'b0};
            end else begin
              sclk_q <= 1'b0;
              if (bit_cnt_q == BIT_CNT_LAST) begin
                state_q <= SDLI_IDLE;
                busy_q <= 1'b0;
              end else begin
                bit_cnt_q <= bit_cnt_q + 5'h01;
              end
            end
          end else begin
            div_q <= div_q + 2'h1;
          end
        end
        default: begin
          state_q <= SDLI_IDLE;
        end
      endcase
    end
  end
endmodule : sdli_host

// file: tb/sdli_monitor.sv
// Checker for the serial link and converter outputs
`timescale 1ns/1ps
module sdli_monitor (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sync_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic [17:0] dac_code_q,
  input wire logic [15:0] core_code_q,
  input wire logic load_pulse_q,
  input wire logic period_start_q
);
  logic sclk_q, done_q, seen_q;
  logic [4:0] cnt_q;
  logic [11:0] per_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) sclk_q <= 1'b0;
    else sclk_q <= sclk;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) cnt_q <= 5'h0;
    else if (sync_n) cnt_q <= 5'h0;
    else if (sclk_q && !sclk) cnt_q <= cnt_q + 5'h1;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) done_q <= 1'b0;
    else if (load_pulse_q) done_q <= 1'b0;
    else if (sclk_q && !sclk && cnt_q == 5'h17) done_q <= 1'b1;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) {seen_q, per_q} <= 13'h0;
    else {seen_q, per_q} <= period_start_q ? {1'b1, 12'h0} : {seen_q, per_q + 12'h1};
  end
  property pair_ok;
    !load_pulse_q && !$past(load_pulse_q) |-> core_code_q == dac_code_q[17:2] || (dac_code_q[1:0] != 2'h0
      && dac_code_q[17:2] != 16'hffff && core_code_q == dac_code_q[17:2] + 16'h1);
  endproperty
  sclk_idle_a: assert property (sync_n |-> !sclk)
    else $error("sclk not idle");
  din_hold_a: assert property ($fell(sclk) |-> $stable(din))
    else $error("din moved at fall");
  sync_gap_a: assert property ($rose(sync_n) |-> sync_n [*2])
    else $error("sync gap short");
  code_hold_a: assert property (!load_pulse_q |-> $stable(dac_code_q))
    else $error("code moved");
  load_done_a: assert property (load_pulse_q |-> done_q)
    else $error("load early");
  load_once_a: assert property (load_pulse_q |=> !load_pulse_q [*8])
    else $error("load again");
  core_pair_a: assert property (pair_ok)
    else $error("core code bad");
  period_len_a: assert property (period_start_q && seen_q |-> per_q == 12'hf9f)
    else $error("period length");
  load_c: cover property (load_pulse_q && dac_code_q[1:0] == 2'h3);
  period_c: cover property (period_start_q && core_code_q != dac_code_q[17:2]);
  gap_c: cover property ($rose(sync_n));
endmodule : sdli_monitor

// file: tb/test_serial_dac_loader_interpolator.sv
// Bench joining both ends, plus a bench-driven second link
`timescale 1ns/1ps
module test_serial_dac_loader_interpolator;
  import sdli_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [17:0] cd = 18'h0;
  logic cv = 1'b0;
  logic cr, ld, ld2, ps, rsv2, bz;
  logic full = 1'b0;
  logic [17:0] dac, dac2, e, c, d;
  logic [15:0] core, core2;
  logic [23:0] wq, wf;
  logic [17:0] q[$];
  logic [17:0] cs[6] = '{18'hffc, 18'hffd, 18'hffe, 18'hfff, 18'h3ffff, 18'h0};
  int failures = 0;
  int check_count = 0;
  int nb, n2, k;
  sdli_link_if lk ();
  sdli_link_if lk2 ();
  always #12.5 clk_sys = ~clk_sys;
  sdli_host i_sdli_host (.clk_sys(clk_sys), .rst_n(rst_n), .link(lk.host_mp), .code_data(cd),
    .code_valid(cv), .code_ready(cr), .busy_q(bz));
  sdli_device i_sdli_device (.clk_sys(clk_sys), .rst_n(rst_n), .link(lk.dev_mp), .dac_code_q(dac),
    .core_code_q(core), .load_pulse_q(ld), .rsv_nonzero_q(), .period_start_q(ps));
  sdli_device #(.MIDSCALE_VARIANT(1'b1)) i_sdli_device_b (.clk_sys(clk_sys), .rst_n(rst_n),
    .link(lk2.dev_mp), .dac_code_q(dac2), .core_code_q(core2), .load_pulse_q(ld2),
    .rsv_nonzero_q(rsv2), .period_start_q());
  sdli_monitor i_sdli_monitor (.clk_sys(clk_sys), .rst_n(rst_n), .sync_n(lk.sync_n), .sclk(lk.sclk),
    .din(lk.din), .dac_code_q(dac), .core_code_q(core), .load_pulse_q(ld), .period_start_q(ps));
  task automatic give_verdict();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input string s, input logic [23:0] x, input logic [23:0] y);
    check_count++;
    if (x !== y) begin
      failures++;
      $display("wrong value %s expected %h seen %h", s, x, y);
    end
  endtask : chk
  task automatic lim(input logic ok);
    if (!ok) begin
      failures++;
      give_verdict();
    end
  endtask : lim
  task automatic tk(input int m);
    repeat (m) @(posedge clk_sys);
    #1;
  endtask : tk
  function automatic int duty(input logic [17:0] v);
    return (v[17:2] == 16'hffff) ? 0 : v[1:0] * SUB_PERIOD_CYC;
  endfunction : duty
  always @(posedge lk.sync_n) begin
    if (rst_n === 1'b1) chk("edges", 24, nb);
    nb = 0;
  end
  always @(negedge lk.sclk) if (!lk.sync_n) begin
    wq = {wq[22:0], lk.din};
    nb++;
    if (nb == 24) wf = wq;
  end
  always @(negedge clk_sys) begin
    if (ld === 1'b1) begin
      e = q.pop_front();
      chk("code", e, dac);
      chk("frame", {4'h0, e, 2'h0}, wf);
    end
    if (ld2 === 1'b1) n2++;
  end
  task automatic push(input logic [17:0] v);
    logic t;
    int n;
    cd = v;
    cv = 1'b1;
    n = 0;
    do begin
      t = cr;
      full |= !cr;
      tk(1);
    end while (t !== 1'b1 && ++n < 999);
    lim(t === 1'b1);
    q.push_back(v);
  endtask : push
  task automatic interp(input logic [17:0] v);
    int h, j;
    push(v);
    cv = 1'b0;
    j = 0;
    do tk(1); while (ld !== 1'b1 && ++j < 999);
    lim(ld === 1'b1);
    do tk(1); while (ps !== 1'b1 && ++j < 6000);
    lim(j < 6000);
    h = 0;
    repeat (4000) begin
      h += (core === v[17:2] + 16'h1);
      tk(1);
    end
    chk("duty", duty(v), h);
  endtask : interp
  task automatic bang(input logic [23:0] f, input int m);
    tk(3);
    lk2.sync_n = 1'b0;
    for (int i = 0; i < m; i++) begin
      lk2.din = f[23 - i % 24];
      lk2.sclk = 1'b1;
      #6;
      lk2.sclk = 1'b0;
      #6;
    end
    tk(8);
    lk2.sync_n = 1'b1;
  endtask : bang
  initial begin
    lk2.sync_n = 1'b1;
    lk2.sclk = 1'b0;
    lk2.din = 1'b0;
    void'($urandom(91873));
    tk(8);
    rst_n = 1'b1;
    chk("rst", RST_CODE_ZERO, dac);
    chk("rst_mid", RST_CODE_MID, dac2);
    chk("rst_core", RST_CODE_MID[17:2], core2);
    tk(3);
    cs[5] = 18'($urandom);
    foreach (cs[i]) interp(cs[i]);
    for (int i = 0; i < 6; i++) push(18'($urandom));
    cv = 1'b0;
    chk("full", 1'b1, full);
    k = 0;
    while (q.size() > 0 && ++k < 2000) tk(1);
    lim(q.size() == 0);
    chk("edges_last", 24, nb);
    chk("busy", 1'b0, bz);
    bang(24'hffffff, 23);
    chk("abort", RST_CODE_MID, dac2);
    chk("noload", 0, n2);
    c = 18'($urandom);
    bang({4'hf, c, 2'h3}, 30);
    chk("load2", c, dac2);
    chk("rsv", 1'b1, rsv2);
    d = ~c;
    bang({4'h0, d, 2'h0}, 24);
    chk("load3", d, dac2);
    chk("rsv0", 1'b0, rsv2);
    chk("nload", 2, n2);
    give_verdict();
  end
endmodule : test_serial_dac_loader_interpolator
